// ### hdl/stc_pkg.sv
// package: register map, fields, reset values and types of the 16-bit timer/counter
package stc_pkg;
  localparam logic [7:0] STC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] STC_OFS_LOW     = 8'h04;
  localparam logic [7:0] STC_OFS_HIGH    = 8'h08;
  localparam logic [7:0] STC_OFS_STATUS  = 8'h0C;
  localparam logic [7:0] STC_OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] STC_OFS_IRQ_CLR = 8'h14;

  localparam int STC_BIT_RUN   = 0;
  localparam int STC_BIT_EXT   = 1;
  localparam int STC_BIT_NSYNC = 2;
  localparam int STC_BIT_OSCEN = 3;
  localparam int STC_BIT_PS_LO = 4;
  localparam int STC_BIT_RUNCK = 6;
  localparam int STC_BIT_WIDE  = 7;
  localparam int STC_BIT_OVF   = 0;

  localparam logic [7:0]  STC_CTRL_RESET = 8'h00;
  localparam logic [15:0] STC_COUNT_MAX  = 16'hFFFF;
  localparam logic [1:0]  STC_OSC_DIV    = 2'h3;

  typedef struct packed {
    logic       wide_access_sel;
    logic [1:0] prescale_sel;
    logic       counter_osc_en;
    logic       ext_sync_n;
    logic       ext_clk_sel;
    logic       counter_run;
  } stc_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } stc_reg_req_t;
endpackage

// ### hdl/stc_ahb_slave.sv
// AHB-Lite slave front end: turns bus transfers into one-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module stc_ahb_slave
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // bus
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  // register side
  output var stc_pkg::stc_reg_req_t req,
  output var logic [7:0]            rd_addr_now
);
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       take;

  // reads decode in the address phase so data is registered by the data phase
  assign take        = hsel && hready && htrans[1];
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign rd_addr_now = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_comb
  begin
    req.wr    = wr_pend_q;
    req.rd    = take && !hwrite;
    req.addr  = wr_pend_q ? wr_addr_q : haddr[7:0];
    req.wdata = hwdata;
  end
endmodule
`default_nettype wire

// ### hdl/stc_prescaler.sv
// clock source pick, external pin always synchronised whatever the sync bit, 1/2/4/8 prescaler, gives a count tick
`timescale 1ns/10ps
`default_nettype none
module stc_prescaler
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // control
  input  wire stc_pkg::stc_ctrl_t ctrl,
  input  wire logic      clr,
  // external pin
  input  wire logic      ext_clk_pin,
  // tick out
  output logic           tick
);
  logic [1:0] s_q;
  logic       last_q;
  logic [1:0] osc_q;
  logic [2:0] ps_q;
  logic       edge_in;
  logic       src;
  logic       limit_hit;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q    <= 2'h0;
      last_q <= 1'b0;
      osc_q  <= 2'h0;
    end
    else
    begin
      s_q    <= {s_q[0], ext_clk_pin};
      last_q <= s_q[1];
      osc_q  <= osc_q + 2'h1;
    end
  end

  // unsynchronised mode uses the same two stages and the same edge stage as synchronised mode
  assign edge_in = ctrl.ext_sync_n ? (s_q[1] && !last_q) : (s_q[1] && !last_q);
  // internal source ignores the sync bit entirely
  assign src = ctrl.ext_clk_sel ? edge_in : (osc_q == STC_OSC_DIV);

  always_comb
  begin
    case (ctrl.prescale_sel)
      2'h0:    limit_hit = 1'b1;
      2'h1:    limit_hit = ps_q[0];
      2'h2:    limit_hit = ps_q[1:0] == 2'h3;
      2'h3:    limit_hit = ps_q == 3'h7;
      default: limit_hit = 1'b1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ps_q <= 3'h0;
    else if (clr)
      ps_q <= 3'h0;
    else if (src && ctrl.counter_run)
      ps_q <= limit_hit ? 3'h0 : ps_q + 3'h1;
  end

  assign tick = src && ctrl.counter_run && limit_hit;
endmodule
`default_nettype wire

// ### hdl/stc_timer.sv
// top: 16-bit timer/counter with control, count bytes and overflow interrupt
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module stc_timer
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins and system
  input  wire logic        ext_clk_pin,
  input  wire logic        sys_clk_from_osc,
  output logic             osc_enable,
  // interrupt
  output logic             irq
);
  stc_reg_req_t req;
  logic [7:0]   rd_addr_now;
  stc_ctrl_t    ctrl_q;
  logic [15:0]  count_q;
  logic [7:0]   hi_buf_q;
  logic         ovf_sts_q;
  logic         ovf_en_q;
  logic [1:0]   runck_q;
  logic         tick;
  logic         wrap;
  logic         wr_ctrl;
  logic         wr_low;
  logic         wr_high;
  logic         rd_low;

  function automatic logic hit(input stc_reg_req_t r, input logic [7:0] ofs);
    hit = r.addr == ofs;
  endfunction

  stc_ahb_slave stc_ahb_slave_i (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .req         (req),
    .rd_addr_now (rd_addr_now)
  );

  stc_prescaler stc_prescaler_i (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ctrl        (ctrl_q),
    .clr         (wr_low || wr_high),
    .ext_clk_pin (ext_clk_pin),
    .tick        (tick)
  );

  assign wr_ctrl = req.wr && hit(req, STC_OFS_CTRL);
  assign wr_low  = req.wr && hit(req, STC_OFS_LOW);
  assign wr_high = req.wr && hit(req, STC_OFS_HIGH);
  assign rd_low  = req.rd && (rd_addr_now == STC_OFS_LOW);
  assign wrap    = tick && (count_q == STC_COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // control register; bit 6 is read-only status

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= stc_ctrl_t'(7'h00);
    else if (wr_ctrl)
      ctrl_q <= {req.wdata[7], req.wdata[5:0]};
  end

  assign osc_enable = ctrl_q.counter_osc_en;

  // status follows the clock switch input sys_clk_from_osc through two sync stages
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      runck_q <= 2'h0;
    else
      runck_q <= {runck_q[0], sys_clk_from_osc};
  end

  ////////////////////////////////////////////////////////////////////////////
  // count; software write wins over a tick in the same cycle

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_q <= 16'h0000;
    else if (wr_low && ctrl_q.wide_access_sel)
      count_q <= {hi_buf_q, req.wdata[7:0]};
    else if (wr_low)
      count_q[7:0] <= req.wdata[7:0];
    else if (wr_high && !ctrl_q.wide_access_sel)
      count_q[15:8] <= req.wdata[7:0];
    else if (tick)
      count_q <= count_q + 16'h0001;
  end

  // one buffer serves both directions; a HIGH write wins over a LOW read in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hi_buf_q <= 8'h00;
    else if (wr_high)
      hi_buf_q <= req.wdata[7:0];
    else if (rd_low && ctrl_q.wide_access_sel)
      hi_buf_q <= count_q[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow interrupt; a wrap in the clear cycle stays set

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ovf_sts_q <= 1'b0;
    else if (wrap)
      ovf_sts_q <= 1'b1;
    else if (req.wr && hit(req, STC_OFS_IRQ_CLR) && req.wdata[STC_BIT_OVF])
      ovf_sts_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ovf_en_q <= 1'b0;
    else if (req.wr && hit(req, STC_OFS_IRQ_EN))
      ovf_en_q <= req.wdata[STC_BIT_OVF];
  end

  assign irq = ovf_sts_q && ovf_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered at the address phase

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (req.rd)
    begin
      case (rd_addr_now)
        STC_OFS_CTRL:
          hrdata <= {24'h000000, ctrl_q.wide_access_sel, runck_q[1], ctrl_q.prescale_sel,
                     ctrl_q.counter_osc_en, ctrl_q.ext_sync_n, ctrl_q.ext_clk_sel,
                     ctrl_q.counter_run};
        STC_OFS_LOW:
          hrdata <= {24'h000000, count_q[7:0]};
        STC_OFS_HIGH:
          hrdata <= {24'h000000, ctrl_q.wide_access_sel ? hi_buf_q : count_q[15:8]};
        STC_OFS_STATUS:
          hrdata <= {31'h00000000, ovf_sts_q};
        STC_OFS_IRQ_EN:
          hrdata <= {31'h00000000, ovf_en_q};
        default:
          hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/stc_timer_sva.sv
// checker: bus answers, oscillator enable, read data, interrupt
`timescale 1ns/10ps
`default_nettype none
module stc_timer_sva
  import stc_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic        osc_enable,
  input wire logic        irq
);
  logic rd_q, wr_q, wc_q, un_q;
  wire  take = hsel & hready & (htrans == 2'h2);
  // data phase flags, one cycle behind the address phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {rd_q, wr_q, wc_q, un_q} <= 4'h0;
    else
      {rd_q, wr_q, wc_q, un_q} <= {take & !hwrite, take & hwrite,
        take & hwrite & (haddr[7:0] == STC_OFS_CTRL),
        take & !hwrite & (haddr[7:0] > STC_OFS_IRQ_CLR)};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wctl;
    wc_q;
  endsequence
  a_bus_ready: assert property (hreadyout) else $error("wait state");
  a_bus_okay: assert property (!hresp) else $error("error response");
  a_osc_follow: assert property (s_wctl |=> osc_enable == $past(hwdata[STC_BIT_OSCEN]))
    else $error("osc enable not written");
  a_osc_cause: assert property ($changed(osc_enable) |-> $past(wc_q))
    else $error("osc enable moved alone");
  a_reset_quiet: assert property ($rose(hresetn) |-> !osc_enable && !irq)
    else $error("not quiet after reset");
  a_unmapped_zero: assert property (un_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_cause: assert property ($fell(irq) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("irq dropped without write");
  a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved");
endmodule
bind stc_timer stc_timer_sva stc_timer_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .osc_enable, .irq);
`default_nettype wire

// ### testbench/stc_ext_src.sv
// partner: external clock source giving bursts of rising edges
`timescale 1ns/10ps
`default_nettype none
module stc_ext_src #(
  parameter int HALF_NS = 33
) (
  // burst request
  input wire logic       go,
  input wire logic [7:0] num,
  // pin
  output logic           ext_clk_pin
);
  initial ext_clk_pin = 1'b0;
  // stands low between bursts, phase unrelated to hclk
  always @(posedge go)
    repeat (num)
    begin
      #HALF_NS ext_clk_pin = 1'b1;
      #HALF_NS ext_clk_pin = 1'b0;
    end
endmodule
`default_nettype wire

// ### testbench/stc_timer_bench.sv
// testbench: register access sequences for the timer/counter
`timescale 1ns/10ps
`default_nettype none
module stc_timer_bench;
  import stc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic        sys_clk_from_osc, osc_enable, irq, ext_pin, go;
  logic [7:0]  num;
  int          n_mismatch, num_checks, i;
  stc_timer stc_timer_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_clk_pin(ext_pin),
    .sys_clk_from_osc, .osc_enable, .irq);
  stc_ext_src stc_ext_src_i (.go, .num, .ext_clk_pin(ext_pin));
  always #4 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task tmo;
    n_mismatch++;
    $display("Error %0t timeout", $time);
    conclude;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] t);
    num_checks++;
    if ((g <= e + t && g + t >= e) !== 1'b1)
    begin
      n_mismatch++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task waitr;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50) tmo;
      @(posedge hclk);
    end
  endtask
  // no wait state is assumed: every phase waits for hready
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitr;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitr;
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] t);
    xf(1'b0, a, 32'h0);
    chk(q, e, t);
  endtask
  task ci(input logic [31:0] e);
    cyc(2);
    chk({31'h0, irq}, e, 32'h0);
  endtask
  task pulse;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    cyc(120);
  endtask
  initial #500000 tmo;
  initial
  begin
    {hresetn, hsel, hwrite, go, sys_clk_from_osc} = 5'h0;
    {haddr, hwdata, htrans, num} = {64'h0, 2'h0, 8'h0A};
    {n_mismatch, num_checks} = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(STC_OFS_CTRL, 32'h0, 32'h0);
    rc(8'h18, 32'h0, 32'h0);
    wr(8'h18, 32'hFF);
    wr(STC_OFS_CTRL, 32'h48);
    rc(STC_OFS_CTRL, 32'h08, 32'h0);
    chk({31'h0, osc_enable}, 32'h1, 32'h0);
    sys_clk_from_osc <= 1'b1;
    cyc(4);
    rc(STC_OFS_CTRL, 32'h48, 32'h0);
    sys_clk_from_osc <= 1'b0;
    cyc(4);
    rc(STC_OFS_CTRL, 32'h08, 32'h0);
    wr(STC_OFS_CTRL, 32'h0);
    wr(STC_OFS_LOW, 32'h12);
    wr(STC_OFS_HIGH, 32'h34);
    rc(STC_OFS_LOW, 32'h12, 32'h0);
    rc(STC_OFS_HIGH, 32'h34, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      wr(STC_OFS_LOW, 32'h0);
      wr(STC_OFS_HIGH, 32'h0);
      wr(STC_OFS_CTRL, {26'h0, i[1:0], 4'h5});
      cyc(256);
      wr(STC_OFS_CTRL, 32'h0);
      rc(STC_OFS_LOW, 32'h40 >> i, 32'h2);
    end
    wr(STC_OFS_LOW, 32'hFE);
    wr(STC_OFS_HIGH, 32'hFF);
    wr(STC_OFS_IRQ_EN, 32'h1);
    wr(STC_OFS_CTRL, 32'h1);
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, 32'h0);
    wr(STC_OFS_CTRL, 32'h0);
    rc(STC_OFS_HIGH, 32'h0, 32'h0);
    wr(STC_OFS_IRQ_EN, 32'h0);
    ci(32'h0);
    rc(STC_OFS_STATUS, 32'h1, 32'h0);
    wr(STC_OFS_IRQ_EN, 32'h1);
    ci(32'h1);
    wr(STC_OFS_IRQ_CLR, 32'h1);
    ci(32'h0);
    rc(STC_OFS_STATUS, 32'h0, 32'h0);
    wr(STC_OFS_LOW, 32'h0);
    wr(STC_OFS_HIGH, 32'h0);
    wr(STC_OFS_CTRL, 32'h03);
    pulse;
    rc(STC_OFS_LOW, 32'h0A, 32'h0);
    wr(STC_OFS_CTRL, 32'h07);
    pulse;
    rc(STC_OFS_LOW, 32'h14, 32'h0);
    wr(STC_OFS_CTRL, 32'h02);
    pulse;
    rc(STC_OFS_LOW, 32'h14, 32'h0);
    wr(STC_OFS_CTRL, 32'h80);
    wr(STC_OFS_HIGH, 32'h56);
    wr(STC_OFS_LOW, 32'h78);
    wr(STC_OFS_HIGH, 32'hAB);
    wr(STC_OFS_CTRL, 32'h0);
    rc(STC_OFS_HIGH, 32'h56, 32'h0);
    rc(STC_OFS_LOW, 32'h78, 32'h0);
    wr(STC_OFS_CTRL, 32'h80);
    rc(STC_OFS_LOW, 32'h78, 32'h0);
    rc(STC_OFS_HIGH, 32'h56, 32'h0);
    wr(STC_OFS_CTRL, 32'h09);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(STC_OFS_CTRL, 32'h0, 32'h0);
    chk({31'h0, osc_enable}, 32'h0, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
